// ---- common/cfs_cfg.svh ----
// Purpose: constants of the codec frame serial slave
// Assumes: included by bare name from common/
// Notes: offsets and field positions are defined here; assertions and bench also use literals
//
// Behaviour
// - frames last at least 64 bit clocks
// - only frame bits 0 to 63 used
// - data out released from bit 64 on
// - tail-zero bit drives tail low instead
// - capture data in on falling bit clock
// - change data out on rising bit clock
// - bit clock is the only link clock
// - interrupt path works without bit clock
// - bypass bit closes reference bypass switch only while internal reference on
// - external select disables internal reference
// - internal reference on only with analog use
// - external reference disconnected when analog idle
// - reference valid after 50 bit clocks
// - bit 21 write flag, bits 17-20 address
// - echo address, reserved output bits zero
// - bits 48-63 carry control data MSB first
// - valid flags in output bits 30, 31
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH
`define CFS_OWN_BITS      7'h40
`define CFS_LAST_BIT      7'h3f
`define CFS_ADDR_LSB      17
`define CFS_WRITE_BIT     21
`define CFS_AVALID_BIT    30
`define CFS_TVALID_BIT    31
`define CFS_TEL_LSB       32
`define CFS_DATA_LSB      48
`define CFS_DATA_BIT      7'h30
`define CFS_AUDIO_KEEP    12
`define CFS_TEL_KEEP      14
`define CFS_REG_TAIL      4'h1
`define CFS_TAIL_BIT      0
`define CFS_REG_IRQ_MASK  4'h2
`define CFS_REG_REF       4'ha
`define CFS_REF_BYP_BIT   14
`define CFS_REF_EXT_BIT   13
`define CFS_REG_RESET     16'h0000
`define CFS_REF_START_BITS 50
`endif

// ---- common/cfs_pkg.sv ----
// Purpose: shared types of the codec frame serial slave
// Assumes: nothing
// Notes: constants live in cfs_cfg.svh
package cfs_pkg;
  // Frame tracking state
  typedef enum logic {
    LS_IDLE  = 1'b0,
    LS_FRAME = 1'b1
  } link_state_e;
  // One control word
  typedef logic [15:0] word_t;
endpackage

// ---- rtl/cfs_link_sync.sv ----
// Purpose: two-stage synchroniser for link pins
// Assumes: inputs asynchronous to clk
// Notes: first stage is read by the second only
`timescale 1ns/1ps
`default_nettype none
module cfs_link_sync #(
  parameter int unsigned W = 3
) (
  // System
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Pins and synchronised copies
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage
  logic [W-1:0] q_q;    // Second stage

  // Per-bit double flop
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_q[i] <= 1'b0;
        q_q[i]    <= 1'b0;
      end else begin
        meta_q[i] <= d[i];
        q_q[i]    <= meta_q[i];
      end
    end
  end
  assign q = q_q;
endmodule
`default_nettype wire

// ---- rtl/cfs_vref_ctrl.sv ----
// Purpose: reference source selection and start-up timing
// Assumes: bit_tick is one pulse per bit clock period
// Notes: start-up is counted in bit clocks, not clk
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"
module cfs_vref_ctrl #(
  parameter int unsigned START_BITS = `CFS_REF_START_BITS
) (
  // System
  input  wire logic clk,
  input  wire logic rst_b,
  // Controls
  input  wire logic bit_tick,
  input  wire logic analog_en,
  input  wire logic ext_sel,
  input  wire logic byp_con,
  // Analog switches and status
  output logic      int_on,
  output logic      ext_conn,
  output logic      byp_sw,
  output logic      valid
);
  logic [7:0] cnt_q, cnt_d; // Bit clocks since enable

  // Source selection follows enables directly
  assign int_on   = analog_en & ~ext_sel;
  assign ext_conn = analog_en & ext_sel;
  assign byp_sw   = byp_con & int_on;

  // Start-up counter; restarts whenever analog goes idle
  always_comb begin
    cnt_d = cnt_q;
    if (!analog_en) begin
      cnt_d = 8'h00;
    end else if (bit_tick && cnt_q < 8'(START_BITS)) begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign valid = (cnt_q == 8'(START_BITS));

  chk_ref_select: assert property (@(posedge clk) disable iff (!rst_b)
    int_on == (analog_en && !ext_sel))
    else $error("internal reference state wrong");
  chk_ref_wait: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(valid) |-> $past(bit_tick) && analog_en)
    else $error("reference valid without full start-up");
endmodule
`default_nettype wire

// ---- rtl/codec_frame_serial_slave.sv ----
// Purpose: device end of the four-wire frame serial link
// Assumes: link pins asynchronous, sampled by clk
// Notes: bit clock is oversampled, at least 6 clk per bit
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"
module codec_frame_serial_slave
  import cfs_pkg::*;
#(
  parameter int unsigned IRQ_W      = 4,
  parameter int unsigned REF_START  = `CFS_REF_START_BITS
) (
  // System
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Link pins
  input  wire logic             bit_clk,
  input  wire logic             frame_sync,
  input  wire logic             ser_din,
  output logic                  ser_dout,
  output logic                  ser_dout_oe_b,
  // Codec samples to send
  input  wire logic [15:0]      audio_tx,
  input  wire logic [15:0]      telecom_tx,
  input  wire logic             audio_tx_valid,
  input  wire logic             telecom_tx_valid,
  // Codec samples received
  output logic      [15:0]      audio_rx,
  output logic      [15:0]      telecom_rx,
  output logic                  audio_rx_valid,
  output logic                  telecom_rx_valid,
  output logic                  frame_done,
  // Local register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // Reference control
  input  wire logic             analog_en,
  output logic                  ref_int_on,
  output logic                  ref_ext_conn,
  output logic                  ref_byp_sw,
  output logic                  ref_valid,
  // Clockless interrupt path
  input  wire logic [IRQ_W-1:0] irq_src,
  output logic                  irq_out
);
  // Synchronised pins
  logic        bclk_s;
  logic        sync_s;
  logic        din_s;
  logic        bclk_prev_q;  // Previous synced bit clock
  logic        rise;         // Bit clock rising edge seen
  logic        fall;         // Bit clock falling edge seen

  // Frame tracking
  link_state_e state_q, state_d;
  logic [6:0]  idx_q, idx_d;   // Current frame bit, 64 = tail
  logic        pend_q, pend_d; // Sync seen, frame starts next
  logic [63:0] rx_q, rx_d;     // Captured input bits
  logic [63:0] tx_q, tx_d;     // Output bits of this frame
  logic        done_q, done_d; // Bit 63 captured
  logic        dout_q, dout_d;
  logic        oe_b_q, oe_b_d;

  // Received fields and stream outputs
  word_t       arx_q, arx_d;
  word_t       trx_q, trx_d;
  logic        arv_q, arv_d;
  logic        trv_q, trv_d;
  logic [3:0]  rx_addr;
  word_t       rx_data;
  logic        rx_wr;

  // Control registers
  word_t       regs_q [16];
  word_t       regs_d [16];
  word_t       rdat_q, rdat_d;
  logic        tail_zero;

  // Pins pass two flops before use
  cfs_link_sync #(
    .W (3)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({bit_clk, frame_sync, ser_din}),
    .q     ({bclk_s, sync_s, din_s})
  );

  // Edge detect on the oversampled bit clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_s;
    end
  end
  assign rise = bclk_s & ~bclk_prev_q;
  assign fall = ~bclk_s & bclk_prev_q;

  // Field extraction, frame bit 0 of a field is its MSB
  always_comb begin
    rx_addr = 4'h0;
    rx_data = 16'h0000;
    for (int j = 0; j < 4; j++) begin
      rx_addr[3-j] = rx_q[`CFS_ADDR_LSB+j];
    end
    for (int j = 0; j < 16; j++) begin
      rx_data[15-j] = rx_q[`CFS_DATA_LSB+j];
    end
    rx_wr = rx_q[`CFS_WRITE_BIT];
  end
  assign tail_zero = regs_q[`CFS_REG_TAIL][`CFS_TAIL_BIT];

  // Frame sequencing, capture and drive
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    pend_d  = pend_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    done_d  = 1'b0;
    dout_d  = dout_q;
    oe_b_d  = oe_b_q;
    if (fall) begin
      if (sync_s) begin
        pend_d = 1'b1;
      end
      if (state_q == LS_FRAME && idx_q < `CFS_OWN_BITS) begin
        rx_d[idx_q[5:0]] = din_s;
        done_d = (idx_q == `CFS_LAST_BIT);
      end
    end
    if (rise) begin
      if (pend_q) begin
        // New frame: counter restarts at bit 0
        state_d = LS_FRAME;
        idx_d   = 7'h00;
        pend_d  = 1'b0;
        tx_d    = 64'h0;
        for (int j = 0; j < 16; j++) begin
          if (j < `CFS_AUDIO_KEEP) begin
            tx_d[j] = audio_tx[15-j];
          end
          if (j < `CFS_TEL_KEEP) begin
            tx_d[`CFS_TEL_LSB+j] = telecom_tx[15-j];
          end
        end
        tx_d[`CFS_AVALID_BIT] = audio_tx_valid;
        tx_d[`CFS_TVALID_BIT] = telecom_tx_valid;
      end else if (state_q == LS_FRAME && idx_q < `CFS_OWN_BITS) begin
        idx_d = idx_q + 7'h01;
      end
      // Read data loads once the address is complete
      if (idx_d == `CFS_DATA_BIT) begin
        for (int j = 0; j < 16; j++) begin
          tx_d[`CFS_DATA_LSB+j] = regs_q[rx_addr][15-j];
        end
      end
      if (state_d == LS_FRAME && idx_d < `CFS_OWN_BITS) begin
        oe_b_d = 1'b0;
        if (idx_d >= 7'(`CFS_ADDR_LSB) && idx_d < 7'(`CFS_WRITE_BIT)) begin
          // Echo follows the address bit now on the input
          dout_d = din_s;
        end else begin
          dout_d = tx_d[idx_d[5:0]];
        end
      end else begin
        dout_d = 1'b0;
        oe_b_d = ~tail_zero;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= LS_IDLE;
      idx_q   <= `CFS_OWN_BITS;
      pend_q  <= 1'b0;
      rx_q    <= 64'h0;
      tx_q    <= 64'h0;
      done_q  <= 1'b0;
      dout_q  <= 1'b0;
      oe_b_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      pend_q  <= pend_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      done_q  <= done_d;
      dout_q  <= dout_d;
      oe_b_q  <= oe_b_d;
    end
  end
  assign ser_dout      = dout_q;
  assign ser_dout_oe_b = oe_b_q;
  assign frame_done    = done_q;

  // Stream outputs refresh only on a set valid flag
  always_comb begin
    arx_d = arx_q;
    trx_d = trx_q;
    arv_d = 1'b0;
    trv_d = 1'b0;
    if (done_q) begin
      arv_d = rx_q[`CFS_AVALID_BIT];
      trv_d = rx_q[`CFS_TVALID_BIT];
      for (int j = 0; j < 16; j++) begin
        if (arv_d) begin
          arx_d[15-j] = (j < `CFS_AUDIO_KEEP) ? rx_q[j] : 1'b0;
        end
        if (trv_d) begin
          trx_d[15-j] = (j < `CFS_TEL_KEEP) ?
                        rx_q[`CFS_TEL_LSB+j] : 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arx_q <= 16'h0000;
      trx_q <= 16'h0000;
      arv_q <= 1'b0;
      trv_q <= 1'b0;
    end else begin
      arx_q <= arx_d;
      trx_q <= trx_d;
      arv_q <= arv_d;
      trv_q <= trv_d;
    end
  end
  assign audio_rx         = arx_q;
  assign telecom_rx       = trx_q;
  assign audio_rx_valid   = arv_q;
  assign telecom_rx_valid = trv_q;

  // Register file; a frame write wins over a local one
  always_comb begin
    regs_d = regs_q;
    rdat_d = rdat_q;
    if (reg_wr) begin
      regs_d[reg_addr] = reg_wdata;
    end
    if (done_q && rx_wr) begin
      regs_d[rx_addr] = rx_data;
    end
    if (reg_rd) begin
      rdat_d = regs_q[reg_addr];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < 16; k++) begin
        regs_q[k] <= `CFS_REG_RESET;
      end
      rdat_q <= 16'h0000;
    end else begin
      regs_q <= regs_d;
      rdat_q <= rdat_d;
    end
  end
  assign reg_rdata = rdat_q;

  // Reference control, timed in bit clocks
  cfs_vref_ctrl #(
    .START_BITS (REF_START)
  ) u_vref (
    .clk       (clk),
    .rst_b     (rst_b),
    .bit_tick  (rise),
    .analog_en (analog_en),
    .ext_sel   (regs_q[`CFS_REG_REF][`CFS_REF_EXT_BIT]),
    .byp_con   (regs_q[`CFS_REG_REF][`CFS_REF_BYP_BIT]),
    .int_on    (ref_int_on),
    .ext_conn  (ref_ext_conn),
    .byp_sw    (ref_byp_sw),
    .valid     (ref_valid)
  );

  // Gates only: keeps working with the bit clock stopped
  assign irq_out = |(irq_src & regs_q[`CFS_REG_IRQ_MASK][IRQ_W-1:0]);

  chk_tail_release: assert property (@(posedge clk) disable iff (!rst_b)
    rise && !pend_q && idx_q >= 7'h3f && !tail_zero |=> ser_dout_oe_b)
    else $error("tail not released");
  chk_tail_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rise && !pend_q && idx_q >= 7'h3f && tail_zero
    |=> !ser_dout_oe_b && !ser_dout)
    else $error("tail not driven low");
  chk_head_drive: assert property (@(posedge clk) disable iff (!rst_b)
    rise && pend_q |=> idx_q == 7'h00 && !ser_dout_oe_b)
    else $error("frame head not driven");
  chk_dout_edge: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(ser_dout) || $changed(ser_dout_oe_b) |-> $past(rise))
    else $error("data out changed off rising edge");
  chk_din_edge: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(rx_q) |-> $past(fall))
    else $error("data in captured off falling edge");
  chk_sync_arm: assert property (@(posedge clk) disable iff (!rst_b)
    fall && sync_s |=> pend_q)
    else $error("sync pulse missed");
  chk_done_last: assert property (@(posedge clk) disable iff (!rst_b)
    frame_done |-> idx_q == 7'h3f && $past(fall))
    else $error("frame done not after bit 63");
  chk_write_commit: assert property (@(posedge clk) disable iff (!rst_b)
    done_q && rx_wr |=> regs_q[$past(rx_addr)] == $past(rx_data))
    else $error("control write lost");
  chk_valid_flag: assert property (@(posedge clk) disable iff (!rst_b)
    rise && pend_q |=> tx_q[30] == $past(audio_tx_valid)
                       && tx_q[31] == $past(telecom_tx_valid))
    else $error("valid flags not placed");
  cov_frame: cover property (@(posedge clk) disable iff (!rst_b)
    frame_done);
  cov_write: cover property (@(posedge clk) disable iff (!rst_b)
    done_q && rx_wr);
  cov_tail: cover property (@(posedge clk) disable iff (!rst_b)
    state_q == LS_FRAME && idx_q == 7'h40 && !ser_dout_oe_b);
endmodule
`default_nettype wire

// ---- tb/cfs_frame_master.sv ----
// Purpose: behavioural frame master driving the codec link
// Assumes: 80 ns bit clock, stopped low between frames
// Notes: samples the data line late in each bit, just before it moves
`timescale 1ns/1ps
`default_nettype none
module cfs_frame_master (
  // Link pins
  output logic      bit_clk,
  output logic      frame_sync,
  output logic      ser_din,
  input  wire logic ser_dout,
  input  wire logic ser_dout_oe_b
);
  // Line as the master sees it; a released line floats
  wire logic line = ser_dout_oe_b ? 1'bz : ser_dout;

  // Idle: clock stands still, sync low
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    ser_din = 1'b0;
  end

  // One frame of nbits; clock high and low 40 ns each
  task automatic run(input logic [63:0] tx, input int nbits,
                     output logic [127:0] rx);
    rx = '0;
    // Step off the clk edge: a pin moving with a sampling edge races
    // the per-bit synchroniser flops against each other
    #1;
    // Sync pulse one bit before frame bit 0
    frame_sync = 1'b1;
    #40 bit_clk = 1'b1;
    #40 bit_clk = 1'b0;
    #40;
    frame_sync = 1'b0;
    // Frames are 64 or 128 bits long
    for (int i = 0; i < nbits; i++) begin
      bit_clk = 1'b1;
      // Bits past 63 talk to another slave: toggle them
      ser_din = (i < 64) ? tx[i] : i[0];
      #40 bit_clk = 1'b0;
      #35 rx[i] = line;
      #5;
    end
    // Clock halts only here, at frame end
    ser_din = ~ser_din;
  endtask
endmodule
`default_nettype wire

// ---- tb/codec_frame_serial_slave_tb_top.sv ----
// Purpose: self-checking bench for the codec frame serial slave
// Assumes: reference start-up shortened to 4 bit clocks
// Notes: frame rows first, then reference table, then hand cases
`timescale 1ns/1ps
`default_nettype none
module codec_frame_serial_slave_tb_top
  import cfs_pkg::*;
;
  // One frame: address, write flag, data, valid flags, length
  typedef struct {
    logic [3:0] a;
    logic       wr;
    word_t      d;
    logic       av;
    logic       tv;
    int         nbits;
  } row_s;

  logic             clk;
  logic             rst_b;
  wire logic        bit_clk;
  wire logic        frame_sync;
  wire logic        ser_din;
  logic             ser_dout;
  logic             ser_dout_oe_b;
  word_t            audio_tx;
  word_t            telecom_tx;
  logic             audio_tx_valid;
  logic             telecom_tx_valid;
  word_t            audio_rx;
  word_t            telecom_rx;
  logic             audio_rx_valid;
  logic             telecom_rx_valid;
  logic             frame_done;
  logic [3:0]       reg_addr;
  word_t            reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  word_t            reg_rdata;
  logic             analog_en;
  logic             ref_int_on;
  logic             ref_ext_conn;
  logic             ref_byp_sw;
  logic             ref_valid;
  logic [3:0]       irq_src;
  logic             irq_out;
  int               errors = 0;
  int               samples_checked = 0;
  int               cycles = 0;
  int               n_done;          // Pulses seen in one frame
  int               n_arx;
  int               n_trx;
  word_t            exp_regs [16];   // Mirror of the register file
  word_t            exp_arx = '0;
  word_t            exp_trx = '0;
  word_t            rd;
  row_s             rows [5] = '{
    '{4'h1, 1'b1, 16'h0001, 1'b1, 1'b1, 64},
    '{4'h1, 1'b0, 16'h0000, 1'b0, 1'b1, 128},
    '{4'h2, 1'b1, 16'h0001, 1'b1, 1'b0, 64},
    '{4'h1, 1'b1, 16'h0000, 1'b0, 1'b0, 64},
    '{4'h2, 1'b0, 16'h0000, 1'b1, 1'b1, 128}};

  codec_frame_serial_slave #(.REF_START(4)) i_dut (.*);
  cfs_frame_master i_master (.bit_clk(bit_clk), .frame_sync(frame_sync),
    .ser_din(ser_din), .ser_dout(ser_dout),
    .ser_dout_oe_b(ser_dout_oe_b));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulse counters and hang guard; a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (frame_done === 1'b1) n_done++;
    if (audio_rx_valid === 1'b1) n_arx++;
    if (telecom_rx_valid === 1'b1) n_trx++;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Place a field MSB first at the lowest frame bit
  function automatic logic [63:0] put(input logic [63:0] f, input int pos,
                                      input int w, input word_t v);
    for (int k = 0; k < w; k++) f[pos + k] = v[w - 1 - k];
    return f;
  endfunction

  task automatic reg_write(input logic [3:0] a, input word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    exp_regs[a] = d;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  task automatic reg_read(input logic [3:0] a, output word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic frame(input row_s r, input int n);
    logic [63:0]  din;
    logic [63:0]  e;
    logic [63:0]  tail;
    logic [127:0] rx;
    @(posedge clk);
    audio_tx <= 16'ha5c3 + 16'(n);
    telecom_tx <= 16'h3c5a - 16'(n);
    audio_tx_valid <= r.av;
    telecom_tx_valid <= r.tv;
    @(posedge clk);
    din = put(64'h0, 0, 16, ~audio_tx);
    din = put(din, 17, 4, {12'h000, r.a});
    din[21] = r.wr;
    din[30] = r.av;
    din[31] = r.tv;
    din = put(din, 32, 16, ~telecom_tx);
    din = put(din, 48, 16, r.d);
    // Reserved output bits stay zero
    e = put(64'h0, 0, 16, audio_tx & 16'hfff0);
    e = put(e, 17, 4, {12'h000, r.a});
    e[30] = r.av;
    e[31] = r.tv;
    e = put(e, 32, 16, telecom_tx & 16'hfffc);
    e = put(e, 48, 16, exp_regs[r.a]);
    tail = exp_regs[1][0] ? 64'h0 : {64{1'bz}};
    n_done = 0;
    n_arx = 0;
    n_trx = 0;
    i_master.run(din, r.nbits, rx);
    repeat (6) @(posedge clk);
    #1;
    // Samples refresh only when their flag was set
    if (r.av) exp_arx = ~audio_tx & 16'hfff0;
    if (r.tv) exp_trx = ~telecom_tx & 16'hfffc;
    if (r.wr) exp_regs[r.a] = r.d;
    check("frame out", e, rx[63:0]);
    check("audio rx", exp_arx, audio_rx);
    check("telecom rx", exp_trx, telecom_rx);
    check("done count", 1, n_done);
    check("audio pulses", r.av, n_arx);
    check("telecom pulses", r.tv, n_trx);
    if (r.nbits > 64) check("tail", tail, rx[127:64]);
  endtask

  initial begin
    rst_b = 1'b0;
    audio_tx = '0;
    telecom_tx = '0;
    audio_tx_valid = 1'b0;
    telecom_tx_valid = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    analog_en = 1'b0;
    irq_src = 4'h0;
    foreach (exp_regs[i]) exp_regs[i] = '0;
    repeat (12) @(posedge clk);
    #1;
    check("oe in reset", 1, ser_dout_oe_b);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("oe before sync", 1, ser_dout_oe_b);
    analog_en <= 1'b1;
    // Frame table; row 1 has tail zero on, row 4 has it off
    for (int i = 0; i < 5; i++) frame(rows[i], i);
    check("ref valid", 1, ref_valid);
    reg_read(4'h1, rd);
    check("tail bit", 0, rd);
    // Reference table: analog enable, register 10, switch states
    for (int i = 0; i < 4; i++) begin
      analog_en <= (i != 0);
      reg_write(4'ha, i == 2 ? 16'h4000 : (i == 3 ? 16'h6000 : '0));
      @(posedge clk);
      #1;
      check("int ref", i < 3 && i != 0, ref_int_on);
      check("ext ref", i == 3, ref_ext_conn);
      check("bypass", i == 2, ref_byp_sw);
      if (i == 0) check("ref off", 0, ref_valid);
      // Bit clock stopped: start-up cannot have completed yet
      if (i == 1) check("ref wait", 0, ref_valid);
    end
    analog_en <= 1'b0;
    @(posedge clk);
    #1;
    check("ext idle", 0, ref_ext_conn);
    // Back-to-back write and read, then an unmapped place
    reg_write(4'h1, 16'h0001);
    reg_read(4'h1, rd);
    check("reg 1", exp_regs[1], rd);
    reg_read(4'h5, rd);
    check("reg 5", 0, rd);
    // Tail now driven low on a long frame
    frame('{4'h5, 1'b0, 16'h0000, 1'b0, 1'b0, 128}, 5);
    // Interrupts with the bit clock stopped
    irq_src <= 4'h2;
    repeat (2) @(posedge clk);
    check("masked irq", 0, irq_out);
    irq_src <= 4'h1;
    repeat (2) @(posedge clk);
    check("irq", 1, irq_out);
    reg_write(4'h2, 16'h0000);
    repeat (2) @(posedge clk);
    check("irq masked", 0, irq_out);
    // Reset in mid-run: tail bit, audio sample, interrupt output and line back to idle
    #1 rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(4'h1, rd);
    check("tail after reset", 0, rd);
    check("audio after reset", 0, audio_rx);
    check("oe after reset", 1, ser_dout_oe_b);
    check("irq after reset", 0, irq_out);
    summarize();
  end
endmodule
`default_nettype wire
